// [tmc_timer16.sv]
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "tmc_timer_map.svh"
// Functional notes
// - One shared 8-bit high-byte holding register serves all 16-bit registers.
// - Low-byte write loads holding byte and written byte together.
// - Low-byte read copies upper byte into holding register same cycle.
// - Match register reads give upper byte directly, holding register untouched.
// - Holding register survives low-byte writes for reuse across registers.
// - Three-bit clock select picks tick source; zero stops counter.
// - Each tick clears, increments or decrements counter per mode.
// - Counter readable and writable whether or not ticking.
// - Host counter write beats same-cycle clear or count.
// - Four-bit waveform mode, split over control A and B, sets sequence.
// - Overflow flag set where mode defines; can request interrupt.
// - Counter is two byte locations; upper location reaches holding register.
// - Matching capture edge copies full counter into capture register.
// - Capture flag set in same cycle capture register loads.
// - Enabled capture flag requests interrupt; cleared when serviced.
// - Writing one clears capture flag; zero leaves it.
// - Trigger from pin; comparator source only on instance one.
// - Capture read low first; upper location returns holding register.
// - Filter changes output after four equal samples, four cycles delay.
// - Capture register writable only when mode uses it as top.
module tmc_timer16 #(
    parameter bit IS_TIMER1 = 1'b1,
    parameter int ADDR_W = 8
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External timer clock and capture sources
    input wire logic ext_clk_pin,
    input wire logic capture_input_pin,
    input wire logic comparator_output,
    // Interrupt requests and service acknowledges
    output logic overflow_irq,
    output logic capture_irq,
    input wire logic overflow_irq_ack,
    input wire logic capture_irq_ack,
    // Observed state
    output logic [15:0] count_value
);

// ==========================================================
// Helpers
function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ma,
                                        input logic [15:0] ic);
    case (m)
        4'd1, 4'd5: top_of = `TMC_TOP_8;
        4'd2, 4'd6: top_of = `TMC_TOP_9;
        4'd3, 4'd7: top_of = `TMC_TOP_10;
        4'd4, 4'd9, 4'd11, 4'd15: top_of = ma;
        4'd8, 4'd10, 4'd12, 4'd14: top_of = ic;
        default: top_of = `TMC_MAX;
    endcase
endfunction

function automatic tmc_timer_pkg::tmc_seq_t seq_of(input logic [3:0] m);
    case (m)
        4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11: seq_of = tmc_timer_pkg::TMC_SEQ_DUAL;
        4'd4, 4'd5, 4'd6, 4'd7, 4'd12, 4'd14, 4'd15: seq_of = tmc_timer_pkg::TMC_SEQ_CLEAR;
        default: seq_of = tmc_timer_pkg::TMC_SEQ_NORMAL;
    endcase
endfunction

// Modes where the capture register defines top
function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'd8) || (m == 4'd10) || (m == 4'd12) || (m == 4'd14);
endfunction

// ==========================================================
// Registers
tmc_timer_pkg::tmc_cfg_t cfg_r;
tmc_timer_pkg::tmc_dir_t dir_r;
logic [7:0] hold_r;
logic [15:0] count_r;
logic [15:0] capture_value_r;
logic [15:0] match_value_regs [3];
logic overflow_flag_r;
logic capture_flag_r;
logic [31:0] prdata_r;
logic [15:0] snap_r;

// ==========================================================
// Bus decode
logic [7:0] offs;
logic setup_ph;
logic access_ph;
logic wr_en;
logic rd_done;
logic mapped;
logic is_match;
logic [1:0] match_idx;
logic match_hi;
logic [7:0] wbyte;

assign offs = 8'(paddr);
assign setup_ph = psel && !penable;
assign access_ph = psel && penable;
assign wr_en = access_ph && pwrite && mapped;
assign rd_done = access_ph && !pwrite && mapped;
assign is_match = (offs >= `TMC_OFF_MATCH_BASE) && (offs <= `TMC_OFF_MATCH_LAST);
assign match_idx = 2'((offs - `TMC_OFF_MATCH_BASE) >> 3);
assign match_hi = offs[2];
assign wbyte = pwdata[7:0];
assign mapped = (offs[1:0] == 2'b00) && (is_match || (offs <= `TMC_OFF_CAP_HI));

// Zero wait states; unaligned or unmapped offsets answer with an error
assign pready = access_ph;
assign pslverr = access_ph && !mapped;
assign prdata = prdata_r;

logic [3:0] wgm;
logic [15:0] top_val;
tmc_timer_pkg::tmc_seq_t seq;
assign wgm = cfg_r.wgm;
assign top_val = top_of(wgm, match_value_regs[0], capture_value_r);
assign seq = seq_of(wgm);
assign count_value = count_r;

// ==========================================================
// Read path: value sampled in setup, driven in access
logic [7:0] rd_byte;
always_comb begin
    rd_byte = `TMC_RST_BYTE;
    if (is_match) begin
        if (match_hi) begin
            rd_byte = match_value_regs[match_idx][15:8];
        end else begin
            rd_byte = match_value_regs[match_idx][7:0];
        end
    end else begin
        case (offs)
            `TMC_OFF_CTRL_A: rd_byte = {6'h00, cfg_r.wgm[1:0]};
            `TMC_OFF_CTRL_B: rd_byte = {cfg_r.filt_en, cfg_r.edge_rise, cfg_r.wgm[3:2],
                                        cfg_r.cs};
            `TMC_OFF_CTRL_C: rd_byte = {5'h00, cfg_r.ovf_ie, cfg_r.cap_ie, cfg_r.comp_sel};
            `TMC_OFF_FLAGS: rd_byte = {6'h00, capture_flag_r, overflow_flag_r};
            `TMC_OFF_CNT_LO: rd_byte = count_r[7:0];
            `TMC_OFF_CNT_HI: rd_byte = hold_r;
            `TMC_OFF_CAP_LO: rd_byte = capture_value_r[7:0];
            `TMC_OFF_CAP_HI: rd_byte = hold_r;
            default: rd_byte = `TMC_RST_BYTE;
        endcase
    end
end

// Snapshot keeps the low and high halves of one read consistent
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_r <= 32'h00000000;
        snap_r <= `TMC_RST_WORD;
    end else if (setup_ph && !pwrite) begin
        prdata_r <= {24'h000000, rd_byte};
        snap_r <= (offs == `TMC_OFF_CAP_LO) ? capture_value_r : count_r;
    end
end

// ==========================================================
// Shared holding register
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        hold_r <= `TMC_RST_BYTE;
    end else if (wr_en && (is_match ? match_hi :
                 (offs == `TMC_OFF_CNT_HI || offs == `TMC_OFF_CAP_HI))) begin
        hold_r <= wbyte;
    end else if (rd_done && (offs == `TMC_OFF_CNT_LO || offs == `TMC_OFF_CAP_LO)) begin
        hold_r <= snap_r[15:8];
    end
end

// ==========================================================
// Control registers
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg_r <= '0;
    end else if (wr_en) begin
        case (offs)
            `TMC_OFF_CTRL_A: cfg_r.wgm[1:0] <= wbyte[`TMC_A_WGM_LSB +: 2];
            `TMC_OFF_CTRL_B: begin
                cfg_r.cs <= wbyte[`TMC_B_CS_LSB +: 3];
                cfg_r.wgm[3:2] <= wbyte[`TMC_B_WGM_LSB +: 2];
                cfg_r.edge_rise <= wbyte[`TMC_B_EDGE_BIT];
                cfg_r.filt_en <= wbyte[`TMC_B_FILT_BIT];
            end
            `TMC_OFF_CTRL_C: begin
                // Comparator source exists only on instance one
                cfg_r.comp_sel <= wbyte[`TMC_C_ACSEL_BIT] && IS_TIMER1;
                cfg_r.cap_ie <= wbyte[`TMC_C_CAPIE_BIT];
                cfg_r.ovf_ie <= wbyte[`TMC_C_OVFIE_BIT];
            end
            default: ;
        endcase
    end
end

// ==========================================================
// Match registers (no compare logic here, storage only)
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (int i = 0; i < 3; i++) begin
            match_value_regs[i] <= `TMC_RST_WORD;
        end
    end else if (wr_en && is_match && !match_hi) begin
        match_value_regs[match_idx] <= {hold_r, wbyte};
    end
end

// ==========================================================
// Tick generation
logic [9:0] presc_r;
logic [2:0] ext_sync_r;
logic timer_tick;
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        presc_r <= 10'h000;
        ext_sync_r <= 3'h0;
    end else begin
        presc_r <= presc_r + 10'h001;
        ext_sync_r <= {ext_sync_r[1:0], ext_clk_pin};
    end
end

always_comb begin
    case (cfg_r.cs)
        3'd1: timer_tick = 1'b1;
        3'd2: timer_tick = &presc_r[2:0];
        3'd3: timer_tick = &presc_r[5:0];
        3'd4: timer_tick = &presc_r[7:0];
        3'd5: timer_tick = &presc_r;
        3'd6: timer_tick = ext_sync_r[2] && !ext_sync_r[1];
        3'd7: timer_tick = !ext_sync_r[2] && ext_sync_r[1];
        default: timer_tick = 1'b0;
    endcase
end

// ==========================================================
// Counter core
logic cnt_wr;
logic ovf_evt;
logic [15:0] count_nxt;
tmc_timer_pkg::tmc_dir_t dir_nxt;
assign cnt_wr = wr_en && (offs == `TMC_OFF_CNT_LO);

always_comb begin
    count_nxt = count_r;
    dir_nxt = dir_r;
    ovf_evt = 1'b0;
    if (timer_tick) begin
        unique case (seq)
            tmc_timer_pkg::TMC_SEQ_NORMAL: begin
                count_nxt = count_r + 16'h0001;
                ovf_evt = (count_r == `TMC_MAX);
            end
            tmc_timer_pkg::TMC_SEQ_CLEAR: begin
                if (count_r == top_val) begin
                    count_nxt = `TMC_RST_WORD;
                end else begin
                    count_nxt = count_r + 16'h0001;
                end
                // CTC modes overflow at MAX, fast modes at TOP
                if (wgm == 4'd4 || wgm == 4'd12) begin
                    ovf_evt = (count_r == `TMC_MAX);
                end else begin
                    ovf_evt = (count_r == top_val);
                end
            end
            tmc_timer_pkg::TMC_SEQ_DUAL: begin
                if (dir_r == tmc_timer_pkg::TMC_DIR_UP) begin
                    if (count_r >= top_val) begin
                        dir_nxt = tmc_timer_pkg::TMC_DIR_DOWN;
                        count_nxt = count_r - 16'h0001;
                    end else begin
                        count_nxt = count_r + 16'h0001;
                    end
                end else if (count_r == `TMC_RST_WORD) begin
                    dir_nxt = tmc_timer_pkg::TMC_DIR_UP;
                    count_nxt = 16'h0001;
                    ovf_evt = 1'b1;
                end else begin
                    count_nxt = count_r - 16'h0001;
                end
            end
        endcase
    end
    if (cnt_wr) begin
        count_nxt = {hold_r, wbyte};
    end
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        count_r <= `TMC_RST_WORD;
        dir_r <= tmc_timer_pkg::TMC_DIR_UP;
    end else begin
        count_r <= count_nxt;
        dir_r <= dir_nxt;
    end
end

// ==========================================================
// Capture input conditioning
logic [1:0] cap_sync_r;
logic [2:0] filt_sh_r;
logic filt_out_r;
logic cap_prev_r;
logic cap_src;
logic cap_lvl;
logic cap_evt;
assign cap_src = cfg_r.comp_sel ? comparator_output : capture_input_pin;

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cap_sync_r <= 2'b00;
        filt_sh_r <= 3'h0;
        filt_out_r <= 1'b0;
        cap_prev_r <= 1'b0;
    end else begin
        cap_sync_r <= {cap_sync_r[0], cap_src};
        filt_sh_r <= {filt_sh_r[1:0], cap_sync_r[1]};
        // Current sample and the last three must agree, so the delay stays at four
        if ({filt_sh_r, cap_sync_r[1]} == 4'hF || {filt_sh_r, cap_sync_r[1]} == 4'h0) begin
            filt_out_r <= cap_sync_r[1];
        end
        cap_prev_r <= cap_lvl;
    end
end

assign cap_lvl = cfg_r.filt_en ? filt_out_r : cap_sync_r[1];
// Capture unit is idle while the capture register is the top value
assign cap_evt = !cap_is_top(wgm) &&
                 (cfg_r.edge_rise ? (cap_lvl && !cap_prev_r)
                                  : (!cap_lvl && cap_prev_r));

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        capture_value_r <= `TMC_RST_WORD;
    end else if (cap_evt) begin
        capture_value_r <= count_r;
    end else if (wr_en && offs == `TMC_OFF_CAP_LO && cap_is_top(wgm)) begin
        capture_value_r <= {hold_r, wbyte};
    end
end

// ==========================================================
// Flags: a set in the clearing cycle wins
logic flag_wr;
assign flag_wr = wr_en && (offs == `TMC_OFF_FLAGS);

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        capture_flag_r <= 1'b0;
        overflow_flag_r <= 1'b0;
    end else begin
        if (cap_evt) begin
            capture_flag_r <= 1'b1;
        end else if (capture_irq_ack || (flag_wr && wbyte[`TMC_F_CAP_BIT])) begin
            capture_flag_r <= 1'b0;
        end
        if (ovf_evt) begin
            overflow_flag_r <= 1'b1;
        end else if (overflow_irq_ack || (flag_wr && wbyte[`TMC_F_OVF_BIT])) begin
            overflow_flag_r <= 1'b0;
        end
    end
end

assign capture_irq = capture_flag_r && cfg_r.cap_ie;
assign overflow_irq = overflow_flag_r && cfg_r.ovf_ie;

endmodule

// [tmc_timer_map.svh]
`ifndef TMC_TIMER_MAP_SVH
`define TMC_TIMER_MAP_SVH
// Byte offsets, one aligned word per 8-bit location
`define TMC_OFF_CTRL_A 8'h00
`define TMC_OFF_CTRL_B 8'h04
`define TMC_OFF_CTRL_C 8'h08
`define TMC_OFF_FLAGS 8'h0C
`define TMC_OFF_CNT_LO 8'h10
`define TMC_OFF_CNT_HI 8'h14
`define TMC_OFF_CAP_LO 8'h18
`define TMC_OFF_CAP_HI 8'h1C
`define TMC_OFF_MATCH_BASE 8'h20
`define TMC_OFF_MATCH_LAST 8'h34
// Field positions
`define TMC_A_WGM_LSB 0
`define TMC_B_CS_LSB 0
`define TMC_B_WGM_LSB 3
`define TMC_B_EDGE_BIT 6
`define TMC_B_FILT_BIT 7
`define TMC_C_ACSEL_BIT 0
`define TMC_C_CAPIE_BIT 1
`define TMC_C_OVFIE_BIT 2
`define TMC_F_OVF_BIT 0
`define TMC_F_CAP_BIT 1
// Reset values and counts
`define TMC_RST_BYTE 8'h00
`define TMC_RST_WORD 16'h0000
`define TMC_MAX 16'hFFFF
`define TMC_TOP_8 16'h00FF
`define TMC_TOP_9 16'h01FF
`define TMC_TOP_10 16'h03FF
`define TMC_FILT_SAMPLES 4
`endif

// [tmc_timer_pkg.sv]
package tmc_timer_pkg;
    // Software configuration gathered from the control registers
    typedef struct packed {
        logic [3:0] wgm;
        logic [2:0] cs;
        logic edge_rise;
        logic filt_en;
        logic comp_sel;
        logic cap_ie;
        logic ovf_ie;
    } tmc_cfg_t;
    typedef enum logic {
        TMC_DIR_UP,
        TMC_DIR_DOWN
    } tmc_dir_t;
    typedef enum logic [1:0] {
        TMC_SEQ_NORMAL,
        TMC_SEQ_CLEAR,
        TMC_SEQ_DUAL
    } tmc_seq_t;
endpackage

// [tmc_host_bfm.sv]
`timescale 1ns/10ps
module tmc_host_bfm (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    // ====================================
    // One byte transfer
    // Callers issue one transfer at a time; the two halves of a two-byte access are not always
    // adjacent, as other transfers fall between them and reuse the holding byte
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
        wait (presetn === 1'b1);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show junk, not the last value
        paddr <= ~a;
        pwdata <= ~{24'h000000, d};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic e);
        xfer(1'b0, a, 8'h00, q, e);
    endtask
endmodule

// [tmc_timer16_chk.sv]
`timescale 1ns/10ps
module tmc_timer16_chk #(
    parameter int ADDR_W = 8
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Capture and interrupts
    input wire logic capture_input_pin,
    input wire logic overflow_irq,
    input wire logic capture_irq,
    input wire logic capture_irq_ack,
    input wire logic [15:0] count_value
);
    logic [7:0] ca_r, cb_r, cc_r, hold_r, snap_r, wb;
    logic hold_ok_r, wr_acc, rd_acc, cnt_wr, cs0, run1, armed;

    default clocking dclk @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ====================================
    // Shadows of control bytes and holding byte
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign cnt_wr = wr_acc && paddr == 8'h10;
    assign wb = pwdata[7:0];
    assign cs0 = cb_r[2:0] == 3'h0;
    assign run1 = cb_r[2:0] == 3'h1 && ca_r[1:0] == 2'h0 && cb_r[4:3] == 2'h0;
    // Capture unit off in modes that use the capture register as top
    assign armed = cb_r[6] && cc_r[1] && !cc_r[0] && !capture_irq && !(cb_r[4] && !ca_r[0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ca_r <= 8'h00;
            cb_r <= 8'h00;
            cc_r <= 8'h00;
        end else if (wr_acc) begin
            case (paddr)
                8'h00: ca_r <= wb;
                8'h04: cb_r <= wb;
                8'h08: cc_r <= wb;
                default: ;
            endcase
        end
    end

    // Capture reads leave the holding byte unknown here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 8'h00;
            snap_r <= 8'h00;
            hold_ok_r <= 1'b1;
        end else begin
            if (psel && !penable && !pwrite && paddr == 8'h10) begin
                snap_r <= count_value[15:8];
            end
            if (wr_acc && paddr[2] && paddr >= 8'h14 && paddr <= 8'h34) begin
                hold_r <= wb;
                hold_ok_r <= 1'b1;
            end else if (rd_acc && paddr == 8'h10) begin
                hold_r <= snap_r;
            end else if (rd_acc && paddr == 8'h18) begin
                hold_ok_r <= 1'b0;
            end
        end
    end

    // ====================================
    // Assertions
    sequence s_rise_armed;
        $rose(capture_input_pin) && armed;
    endsequence
    sequence s_filt_wait;
        !capture_irq[*4] ##[1:5] capture_irq;
    endsequence

    a_low_write_load: assert property (
        cnt_wr && hold_ok_r |=> count_value == {$past(hold_r), $past(wb)})
        else $error("counter low write mismatch");
    a_high_read_hold: assert property (
        rd_acc && paddr == 8'h14 && hold_ok_r |-> prdata[7:0] == hold_r)
        else $error("counter high read not holding byte");
    a_stopped_count: assert property (
        cs0 && $past(cs0, 3) && !cnt_wr |=> $stable(count_value))
        else $error("counter moved while stopped");
    a_count_step: assert property (
        run1 && $past(run1, 3) && !cnt_wr |=> count_value == $past(count_value) + 16'h0001)
        else $error("counter did not step by one");
    a_overflow_set: assert property (
        run1 && cc_r[2] && count_value == 16'hFFFF && !cnt_wr |-> ##[1:2] overflow_irq)
        else $error("overflow not flagged at wrap");
    a_irq_masked: assert property (
        (overflow_irq |-> cc_r[2]) and (capture_irq |-> cc_r[1]))
        else $error("interrupt request while disabled");
    a_ack_clears: assert property (
        capture_irq_ack && $stable(capture_input_pin) |=> !capture_irq)
        else $error("capture flag not cleared by service");
    a_zero_write_keeps: assert property (
        wr_acc && paddr == 8'h0C && !wb[1] && capture_irq |=> capture_irq)
        else $error("zero write cleared capture flag");
    a_capture_fast: assert property (
        (s_rise_armed and !cb_r[7]) |-> ##[1:4] capture_irq)
        else $error("unfiltered capture latency wrong");
    a_capture_filtered: assert property (
        (s_rise_armed and cb_r[7]) |-> s_filt_wait)
        else $error("filtered capture latency wrong");
    a_edge_ignored: assert property (
        $fell(capture_input_pin) && armed |=> !capture_irq[*6])
        else $error("capture on unselected edge");
endmodule

bind tmc_timer16 tmc_timer16_chk #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .capture_input_pin(capture_input_pin),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq),
    .capture_irq_ack(capture_irq_ack), .count_value(count_value)
);

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
    logic pclk, presetn, ext_clk_pin, capture_input_pin, comparator_output;
    logic overflow_irq_ack, capture_irq_ack, overflow_irq, capture_irq;
    logic psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr, rdat;
    logic [31:0] pwdata, prdata;
    logic [15:0] count_value;
    int bad_count, compares, cycles;

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    tmc_host_bfm u_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    tmc_timer16 #(.IS_TIMER1(1'b1), .ADDR_W(8)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
        .capture_input_pin(capture_input_pin), .comparator_output(comparator_output),
        .overflow_irq(overflow_irq), .capture_irq(capture_irq),
        .overflow_irq_ack(overflow_irq_ack), .capture_irq_ack(capture_irq_ack),
        .count_value(count_value));

    // ====================================
    // Helpers
    task automatic end_of_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, rdat, rerr);
        chk("read byte", {8'h00, rdat}, {8'h00, e});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // Pin changes land long before the next check, past any filter delay
    task automatic drive(input logic p, input logic c);
        @(posedge pclk) begin
            capture_input_pin <= p;
            comparator_output <= c;
        end
        tick(12);
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ====================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        ext_clk_pin = 1'b0;
        capture_input_pin = 1'b0;
        comparator_output = 1'b0;
        overflow_irq_ack = 1'b0;
        capture_irq_ack = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(8'h04, 8'h00);
        rchk(8'h0C, 8'h00);
        u_host.wr(8'h14, 8'h01);
        u_host.wr(8'h10, 8'hFF);
        #1 chk("count", count_value, 16'h01FF);
        u_host.wr(8'h14, 8'h56);
        u_host.wr(8'h20, 8'h78);
        u_host.wr(8'h28, 8'h9A);
        rchk(8'h10, 8'hFF);
        rchk(8'h24, 8'h56);
        rchk(8'h14, 8'h01);
        rchk(8'h28, 8'h9A);
        rchk(8'h2C, 8'h56);
        u_host.wr(8'h04, 8'h01);
        tick(20);
        u_host.wr(8'h14, 8'h40);
        u_host.wr(8'h10, 8'h00);
        #1 chk("count", count_value, 16'h4000);
        @(posedge pclk) #1 chk("count", count_value, 16'h4001);
        u_host.wr(8'h04, 8'h00);
        u_host.wr(8'h14, 8'h12);
        u_host.wr(8'h10, 8'h34);
        tick(20);
        chk("count", count_value, 16'h1234);
        u_host.wr(8'h08, 8'h04);
        u_host.wr(8'h14, 8'hFF);
        u_host.wr(8'h10, 8'hF8);
        u_host.wr(8'h04, 8'h01);
        tick(20);
        chk("overflow irq", {15'h0000, overflow_irq}, 16'h0001);
        u_host.wr(8'h04, 8'h00);
        @(posedge pclk) overflow_irq_ack <= 1'b1;
        @(posedge pclk) overflow_irq_ack <= 1'b0;
        tick(2);
        chk("overflow irq", {15'h0000, overflow_irq}, 16'h0000);
        u_host.wr(8'h14, 8'h23);
        u_host.wr(8'h10, 8'h45);
        u_host.wr(8'h04, 8'h40);
        u_host.wr(8'h08, 8'h02);
        drive(1'b1, 1'b0);
        chk("capture irq", {15'h0000, capture_irq}, 16'h0001);
        rchk(8'h18, 8'h45);
        rchk(8'h1C, 8'h23);
        u_host.wr(8'h0C, 8'h01);
        #1 chk("capture irq", {15'h0000, capture_irq}, 16'h0001);
        u_host.wr(8'h0C, 8'h02);
        #1 chk("capture irq", {15'h0000, capture_irq}, 16'h0000);
        drive(1'b0, 1'b0);
        chk("capture irq", {15'h0000, capture_irq}, 16'h0000);
        u_host.wr(8'h04, 8'hC0);
        drive(1'b1, 1'b0);
        chk("capture irq", {15'h0000, capture_irq}, 16'h0001);
        @(posedge pclk) capture_irq_ack <= 1'b1;
        @(posedge pclk) capture_irq_ack <= 1'b0;
        tick(2);
        chk("capture irq", {15'h0000, capture_irq}, 16'h0000);
        u_host.wr(8'h08, 8'h03);
        drive(1'b0, 1'b0);
        drive(1'b0, 1'b1);
        chk("capture irq", {15'h0000, capture_irq}, 16'h0001);
        u_host.wr(8'h1C, 8'h77);
        u_host.wr(8'h18, 8'h66);
        rchk(8'h18, 8'h45);
        u_host.wr(8'h00, 8'h02);
        u_host.wr(8'h04, 8'h18);
        u_host.wr(8'h1C, 8'h77);
        u_host.wr(8'h18, 8'h66);
        rchk(8'h18, 8'h66);
        rchk(8'h1C, 8'h77);
        // Clear-on-top mode with match0 as top, counted on external rising edges
        u_host.wr(8'h24, 8'h00);
        u_host.wr(8'h20, 8'h03);
        u_host.wr(8'h10, 8'h02);
        u_host.wr(8'h00, 8'h00);
        u_host.wr(8'h04, 8'h0F);
        @(posedge pclk) ext_clk_pin <= 1'b1;
        tick(6);
        chk("count", count_value, 16'h0003);
        @(posedge pclk) ext_clk_pin <= 1'b0;
        tick(6);
        chk("count", count_value, 16'h0003);
        @(posedge pclk) ext_clk_pin <= 1'b1;
        tick(6);
        chk("count", count_value, 16'h0000);
        u_host.rd(8'h40, rdat, rerr);
        chk("unmapped error", {15'h0000, rerr}, 16'h0001);
        end_of_test();
    end
endmodule
